// File: core/bus_traffic_replay_engine.sv
// replay engine: fetches recorded monitor entries from a circular buffer in
// global ram and re-issues them as bus master; apb registers, one clock.
// assumes a ram read port that answers memReq with a one-cycle memAck, and
// a bus encoder that takes txWord on txValid and txReady.
`timescale 1ns/1ps
module bus_traffic_replay_engine #(
    parameter int BUF_BYTES = replay_pkg::BUF_BYTES,
    parameter int TO_WIDTH  = 16
) (
    input  wire logic               clk,
    input  wire logic               resetn,
    input  wire logic               clkEn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    output logic                    memReq,
    output logic [31:0]             memAddr,
    input  wire logic               memAck,
    input  wire logic [31:0]        memData,
    output logic                    txValid,
    output replay_pkg::tx_word_type txWord,
    input  wire logic               txReady,
    input  wire logic               rxValid,
    output logic                    tagValid,
    output replay_pkg::tag_out_type tagOut,
    output logic                    halfIntr,
    output logic                    replayActive,
    output logic                    bcEnable,
    output logic                    rtEnable,
    output logic                    monEnable
);

    localparam int WORDS = BUF_BYTES / 4;
    localparam int PW    = $clog2(WORDS);

    if ((WORDS < 4) || ((1 << PW) != WORDS) || (TO_WIDTH < 2) || (TO_WIDTH > 32))
    begin : g_chk
        $error("buffer size must be a power of two words, timeout width 2..32");
    end

    logic [1:0]              rstSyncFf;
    logic                    rstn;
    replay_pkg::state_type   stateFf;
    replay_pkg::state_type   nxt_state;
    replay_pkg::ctrl_type    ctrlFf;
    replay_pkg::ctrl_type    nxt_ctrl;
    logic [29:0]             countFf;
    logic [29:0]             nxt_count;
    logic [31:0]             rtDisFf;
    logic [31:0]             nxt_rtDis;
    logic [TO_WIDTH-1:0]     timeoutFf;
    logic [TO_WIDTH-1:0]     nxt_timeout;
    logic [31:0]             baseFf;
    logic [31:0]             nxt_base;
    logic                    refusedFf;
    logic                    nxt_refused;
    logic [15:0]             halfCntFf;
    logic [15:0]             nxt_halfCnt;
    logic [PW-1:0]           ptrFf;
    logic [PW-1:0]           nxt_ptr;
    logic [31:0]             addrFf;
    logic [31:0]             nxt_addr;
    logic [31:0]             entryFf;
    logic [31:0]             nxt_entry;
    logic                    curDisFf;
    logic                    nxt_curDis;
    logic                    curTxFf;
    logic                    nxt_curTx;
    replay_pkg::tx_word_type txFf;
    replay_pkg::tx_word_type nxt_tx;
    replay_pkg::tag_out_type tagFf;
    replay_pkg::tag_out_type nxt_tag;
    logic                    tagValidFf;
    logic                    nxt_tagValid;
    logic                    halfFf;
    logic                    nxt_half;
    logic                    halfEvtFf;
    logic                    nxt_halfEvt;
    logic [31:0]             prdataFf;
    logic [31:0]             nxt_prdata;
    logic                    slvErrFf;
    logic                    nxt_slvErr;
    logic                    timerStart;
    logic                    timedOut;
    logic                    wrAcc;
    logic                    startReq;
    logic [3:0]              entType;
    logic [15:0]             busWord;

    // a write lands only at the access edge
    function automatic logic mapped(input logic [11:0] a);
        if (a == replay_pkg::CTRL_OFF) mapped = 1'b1;
        else if (a == replay_pkg::BYTES_OFF) mapped = 1'b1;
        else if (a == replay_pkg::RTDIS_OFF) mapped = 1'b1;
        else if (a == replay_pkg::TIMEOUT_OFF) mapped = 1'b1;
        else if (a == replay_pkg::STATUS_OFF) mapped = 1'b1;
        else if (a == replay_pkg::HALFCNT_OFF) mapped = 1'b1;
        else if (a == replay_pkg::BASE_OFF) mapped = 1'b1;
        else mapped = 1'b0;
    endfunction

    // after an entry: next fetch unless the count ran out
    function automatic replay_pkg::state_type after_entry(input logic [29:0] cnt);
        after_entry = (cnt == '0) ? replay_pkg::ST_IDLE : replay_pkg::ST_FETCH;
    endfunction

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rstSyncFf <= 2'b00;
        end
        else if (clkEn)
        begin
            rstSyncFf <= {rstSyncFf[0], 1'b1};
        end
    end

    assign rstn = rstSyncFf[1];
    assign wrAcc = psel && penable && pwrite;
    assign startReq = wrAcc && (paddr == replay_pkg::CTRL_OFF) && pwdata[replay_pkg::START_BIT];
    assign entType = entryFf[31:replay_pkg::TYPE_LSB];
    assign busWord = entryFf[15:0];

    // register file
    always_comb
    begin
        nxt_ctrl = ctrlFf;
        nxt_rtDis = rtDisFf;
        nxt_timeout = timeoutFf;
        nxt_base = baseFf;
        nxt_refused = refusedFf;
        nxt_prdata = prdataFf;
        nxt_slvErr = slvErrFf;
        if (psel && !penable)
        begin
            nxt_slvErr = !mapped(paddr);
            nxt_prdata = 32'h0000_0000;
            if (paddr == replay_pkg::CTRL_OFF) nxt_prdata = {25'h0, ctrlFf};
            else if (paddr == replay_pkg::BYTES_OFF) nxt_prdata = {2'b00, countFf};
            else if (paddr == replay_pkg::RTDIS_OFF) nxt_prdata = rtDisFf;
            else if (paddr == replay_pkg::TIMEOUT_OFF) nxt_prdata = 32'(timeoutFf);
            else if (paddr == replay_pkg::STATUS_OFF) nxt_prdata = {30'h0, refusedFf, replayActive};
            else if (paddr == replay_pkg::HALFCNT_OFF) nxt_prdata = {16'h0000, halfCntFf};
            else if (paddr == replay_pkg::BASE_OFF) nxt_prdata = baseFf;
        end
        if (wrAcc)
        begin
            if (paddr == replay_pkg::CTRL_OFF)
            begin
                if (pwdata[replay_pkg::REPLAY_BIT] && pwdata[replay_pkg::BC_BIT])
                begin
                    nxt_refused = 1'b1;
                end
                else
                begin
                    nxt_ctrl.replayEn = pwdata[replay_pkg::REPLAY_BIT];
                    nxt_ctrl.bcEn = pwdata[replay_pkg::BC_BIT];
                end
                // no interlock with rt or monitor
                nxt_ctrl.rtEn = pwdata[replay_pkg::RT_BIT];
                nxt_ctrl.monEn = pwdata[replay_pkg::MON_BIT];
                nxt_ctrl.halfIntEn = pwdata[replay_pkg::HALFINT_BIT];
                nxt_ctrl.tagMode = replay_pkg::tag_mode_type'(pwdata[replay_pkg::TAG_LSB +: 2]);
            end
            else if (paddr == replay_pkg::RTDIS_OFF) nxt_rtDis = pwdata;
            else if (paddr == replay_pkg::TIMEOUT_OFF) nxt_timeout = pwdata[TO_WIDTH-1:0];
            else if (paddr == replay_pkg::BASE_OFF) nxt_base = pwdata;
            else if (paddr == replay_pkg::STATUS_OFF)
            begin
                // set of the same cycle wins over the clear
                if (pwdata[replay_pkg::REFUSED_BIT]) nxt_refused = 1'b0;
            end
        end
        // refusal flag stays set on simultaneous clear
        if (wrAcc && (paddr == replay_pkg::CTRL_OFF) && pwdata[replay_pkg::REPLAY_BIT]
            && pwdata[replay_pkg::BC_BIT])
        begin
            nxt_refused = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrlFf <= '0;
            rtDisFf <= 32'h0000_0000;
            timeoutFf <= TO_WIDTH'(replay_pkg::TIMEOUT_RST);
            baseFf <= replay_pkg::BASE_RST;
            refusedFf <= 1'b0;
            prdataFf <= 32'h0000_0000;
            slvErrFf <= 1'b0;
        end
        else if (clkEn)
        begin
            ctrlFf <= nxt_ctrl;
            rtDisFf <= nxt_rtDis;
            timeoutFf <= nxt_timeout;
            baseFf <= nxt_base;
            refusedFf <= nxt_refused;
            prdataFf <= nxt_prdata;
            slvErrFf <= nxt_slvErr;
        end
    end

    // replay sequencer
    always_comb
    begin
        nxt_state = stateFf;
        nxt_count = countFf;
        nxt_halfCnt = halfCntFf;
        nxt_ptr = ptrFf;
        nxt_entry = entryFf;
        nxt_curDis = curDisFf;
        nxt_curTx = curTxFf;
        nxt_tx = txFf;
        nxt_tag = tagFf;
        nxt_tagValid = 1'b0;
        nxt_half = 1'b0;
        nxt_halfEvt = halfEvtFf;
        timerStart = 1'b0;
        memReq = 1'b0;
        txValid = 1'b0;
        if (wrAcc && (paddr == replay_pkg::BYTES_OFF) && (stateFf == replay_pkg::ST_IDLE))
        begin
            nxt_count = pwdata[31:2];
            nxt_ptr = '0;
        end
        case (stateFf)
            replay_pkg::ST_IDLE:
            begin
                if (startReq && ctrlFf.replayEn && (countFf != '0))
                begin
                    nxt_state = replay_pkg::ST_FETCH;
                end
            end
            replay_pkg::ST_FETCH:
            begin
                memReq = 1'b1;
                if (memAck)
                begin
                    // word arrives lane 0 in bits 7:0
                    nxt_entry = memData;
                    nxt_count = countFf - 1'b1;
                    nxt_ptr = ptrFf + 1'b1;
                    // last word of a half marks that half done
                    nxt_halfEvt = (ptrFf[PW-2:0] == '1);
                    nxt_state = replay_pkg::ST_DECODE;
                end
            end
            replay_pkg::ST_DECODE:
            begin
                nxt_state = after_entry(countFf);
                if (halfEvtFf)
                begin
                    nxt_halfCnt = halfCntFf + 1'b1;
                    nxt_half = ctrlFf.halfIntEn;
                    nxt_halfEvt = 1'b0;
                end
                if (entType == replay_pkg::ENT_EMPTY)
                begin
                    nxt_state = replay_pkg::ST_IDLE;
                end
                else if (entType[3])
                begin
                    nxt_tx.secondary = entType[2];
                    nxt_tx.kind = replay_pkg::word_kind_type'(entType[1:0]);
                    nxt_tx.word = busWord;
                    case (replay_pkg::word_kind_type'(entType[1:0]))
                        replay_pkg::WORD_CMD:
                        begin
                            nxt_curDis = rtDisFf[busWord[15:replay_pkg::RTADDR_LSB]];
                            nxt_curTx = busWord[replay_pkg::TXDIR_BIT];
                            nxt_state = replay_pkg::ST_SEND;
                        end
                        replay_pkg::WORD_DATA:
                        begin
                            // live rt supplies its own data
                            if (!(curDisFf && curTxFf)) nxt_state = replay_pkg::ST_SEND;
                        end
                        replay_pkg::WORD_STAT:
                        begin
                            if (curDisFf)
                            begin
                                timerStart = 1'b1;
                                nxt_state = replay_pkg::ST_WAIT;
                            end
                            else
                            begin
                                nxt_state = replay_pkg::ST_SEND;
                            end
                        end
                        default:
                        begin
                            nxt_state = replay_pkg::ST_SEND;
                        end
                    endcase
                end
                else if (entType == replay_pkg::ENT_TAGLO)
                begin
                    nxt_tag = {1'b0, entryFf[26:0]};
                    nxt_tagValid = (ctrlFf.tagMode != replay_pkg::TAG_NONE);
                end
                // high tag only in full mode
                else if (entType == replay_pkg::ENT_TAGHI)
                begin
                    nxt_tag = {1'b1, entryFf[26:0]};
                    nxt_tagValid = (ctrlFf.tagMode == replay_pkg::TAG_FULL);
                end
            end
            replay_pkg::ST_SEND:
            begin
                txValid = 1'b1;
                if (txReady) nxt_state = after_entry(countFf);
            end
            replay_pkg::ST_WAIT:
            begin
                // timeout moves on to the next entry
                if (rxValid || timedOut) nxt_state = after_entry(countFf);
            end
            default:
            begin
                nxt_state = replay_pkg::ST_IDLE;
            end
        endcase
        // clearing the enable aborts a running replay
        if (!ctrlFf.replayEn) nxt_state = replay_pkg::ST_IDLE;
        nxt_addr = baseFf + {{(30 - PW){1'b0}}, nxt_ptr, 2'b00};
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            stateFf <= replay_pkg::ST_IDLE;
            countFf <= '0;
            halfCntFf <= 16'h0000;
            ptrFf <= '0;
            addrFf <= replay_pkg::BASE_RST;
            entryFf <= 32'h0000_0000;
            curDisFf <= 1'b0;
            curTxFf <= 1'b0;
            txFf <= '0;
            tagFf <= '0;
            tagValidFf <= 1'b0;
            halfFf <= 1'b0;
            halfEvtFf <= 1'b0;
        end
        else if (clkEn)
        begin
            stateFf <= nxt_state;
            countFf <= nxt_count;
            halfCntFf <= nxt_halfCnt;
            ptrFf <= nxt_ptr;
            addrFf <= nxt_addr;
            entryFf <= nxt_entry;
            curDisFf <= nxt_curDis;
            curTxFf <= nxt_curTx;
            txFf <= nxt_tx;
            tagFf <= nxt_tag;
            tagValidFf <= nxt_tagValid;
            halfFf <= nxt_half;
            halfEvtFf <= nxt_halfEvt;
        end
    end

    replay_timer #(
        .WIDTH (TO_WIDTH)
    ) u_timer (
        .clk     (clk),
        .rstn    (rstn),
        .clkEn   (clkEn),
        .start   (timerStart),
        .cancel  (rxValid),
        .limit   (timeoutFf),
        .expired (timedOut)
    );

    // zero wait states keep the bus simple
    assign pready = penable;
    assign pslverr = penable && slvErrFf;
    assign prdata = prdataFf;
    assign memAddr = addrFf;
    assign txWord = txFf;
    assign tagValid = tagValidFf;
    assign tagOut = tagFf;
    assign halfIntr = halfFf;
    assign replayActive = (stateFf != replay_pkg::ST_IDLE);
    assign bcEnable = ctrlFf.bcEn;
    assign rtEnable = ctrlFf.rtEn;
    assign monEnable = ctrlFf.monEn;

endmodule

// File: core/replay_pkg.sv
// constants, field layouts and types for the bus traffic replay engine
// assumes a 10 MHz system clock and 32-bit apb register access
package replay_pkg;

    localparam int          CLK_MHZ         = 10;
    localparam int          RSP_TIMEOUT_US  = 14;
    localparam int          RSP_TIMEOUT_CYC = RSP_TIMEOUT_US * CLK_MHZ;
    localparam int          BUF_BYTES       = 32'h0002_0000;
    localparam int          HALF_BYTES      = 32'h0001_0000;

    localparam logic [11:0] CTRL_OFF        = 12'h000;
    localparam logic [11:0] BYTES_OFF       = 12'h004;
    localparam logic [11:0] RTDIS_OFF       = 12'h008;
    localparam logic [11:0] TIMEOUT_OFF     = 12'h00C;
    localparam logic [11:0] STATUS_OFF      = 12'h010;
    localparam logic [11:0] HALFCNT_OFF     = 12'h014;
    localparam logic [11:0] BASE_OFF        = 12'h018;

    localparam int          REPLAY_BIT      = 0;
    localparam int          BC_BIT          = 1;
    localparam int          RT_BIT          = 2;
    localparam int          MON_BIT         = 3;
    localparam int          HALFINT_BIT     = 4;
    localparam int          TAG_LSB         = 5;
    localparam int          START_BIT       = 8;
    localparam int          RUN_BIT         = 0;
    localparam int          REFUSED_BIT     = 1;
    localparam int          TYPE_LSB        = 28;
    localparam int          RTADDR_LSB      = 11;
    localparam int          TXDIR_BIT       = 10;

    localparam logic [15:0] TIMEOUT_RST     = 16'(RSP_TIMEOUT_CYC);
    localparam logic [31:0] BASE_RST        = 32'h0000_0000;

    typedef enum logic [3:0] {
        ENT_EMPTY = 4'h0,
        ENT_ERROR = 4'h1,
        ENT_TAGLO = 4'h2,
        ENT_TAGHI = 4'h3
    } entry_kind_type;

    typedef enum logic [1:0] {
        WORD_CMD  = 2'b00,
        WORD_CMD2 = 2'b01,
        WORD_DATA = 2'b10,
        WORD_STAT = 2'b11
    } word_kind_type;

    typedef enum logic [1:0] {
        TAG_NONE = 2'b00,
        TAG_LOW  = 2'b01,
        TAG_FULL = 2'b10
    } tag_mode_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FETCH = 3'b001,
        ST_DECODE = 3'b010,
        ST_SEND = 3'b011,
        ST_WAIT = 3'b100
    } state_type;

    typedef struct packed {
        logic          secondary;
        word_kind_type kind;
        logic [15:0]   word;
    } tx_word_type;

    typedef struct packed {
        logic        high;
        logic [26:0] value;
    } tag_out_type;

    // field order follows the control word, so readback is the struct itself
    typedef struct packed {
        tag_mode_type tagMode;
        logic         halfIntEn;
        logic         monEn;
        logic         rtEn;
        logic         bcEn;
        logic         replayEn;
    } ctrl_type;

endpackage

// File: core/replay_timer.sv
// one-shot down counter used as the live response timeout
// assumes an active-low reset, asserted at once and released in step with clk
`timescale 1ns/1ps
module replay_timer #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             clkEn,
    input  wire logic             start,
    input  wire logic             cancel,
    input  wire logic [WIDTH-1:0] limit,
    output logic                  expired
);

    logic [WIDTH-1:0] cntFf;
    logic [WIDTH-1:0] nxt_cnt;
    logic             activeFf;
    logic             nxt_active;

    if (WIDTH < 2)
    begin : g_chk
        $error("timer width too small");
    end

    always_comb
    begin
        nxt_cnt = cntFf;
        nxt_active = activeFf;
        expired = activeFf && (cntFf == '0);
        if (start)
        begin
            // zero limit still waits one cycle
            nxt_cnt = (limit == '0) ? '0 : limit - 1'b1;
            nxt_active = 1'b1;
        end
        else if (cancel || expired)
        begin
            nxt_active = 1'b0;
        end
        else if (activeFf)
        begin
            nxt_cnt = cntFf - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cntFf <= '0;
            activeFf <= 1'b0;
        end
        else if (clkEn)
        begin
            cntFf <= nxt_cnt;
            activeFf <= nxt_active;
        end
    end

endmodule

// File: tb/replay_monitor.sv
// checker on the replay engine ports
// assumes buffer base left at zero
`timescale 1ns/1ps
module replay_monitor #(parameter int BUF_BYTES = 256) (
    input wire logic clk, resetn, psel, penable, pwrite, memReq, memAck, txValid,
    input wire logic txReady, tagValid, halfIntr, replayActive, bcEnable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, memAddr, memData,
    input wire replay_pkg::tx_word_type txWord
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    mem_hold_a: assert property (memReq && !memAck |=>
        memReq && $stable(memAddr)) else $error("fetch dropped");
    tx_hold_a: assert property (txValid && !txReady |=>
        txValid && $stable(txWord)) else $error("word dropped");
    bc_refuse_a: assert property (psel && penable && pwrite &&
        paddr == replay_pkg::CTRL_OFF && pwdata[1:0] == 2'h3 |=> $stable(bcEnable))
        else $error("both modes");
    buf_range_a: assert property (memReq |->
        memAddr < BUF_BYTES && memAddr[1:0] == 2'h0) else $error("address");
    empty_stop_a: assert property (memAck && memData[31:28] == 4'h0 |->
        ##[1:3] !replayActive) else $error("no stop");
    bus_master_a: assert property (txValid |-> replayActive) else $error("idle tx");
    half_pulse_a: assert property (halfIntr |=> !halfIntr) else $error("irq");
    tag_pulse_a: assert property (tagValid |=> !tagValid) else $error("tag");
endmodule
bind bus_traffic_replay_engine replay_monitor #(.BUF_BYTES(BUF_BYTES)) mon_u (.*);

// File: tb/bus_side_model.sv
// bus side: stalling encoder and a live terminal
// assumes words taken on txValid and txReady at the edge
`timescale 1ns/1ps
module bus_side_model (
    input wire logic clk, txValid, answer,
    input wire replay_pkg::tx_word_type txWord,
    output logic txReady = 1'h0,
    output logic rxValid = 1'h0
);
    int waitCnt = 0;
    always @(posedge clk)
    begin
        txReady <= $urandom % 3 != 0;
        rxValid <= answer && waitCnt == 1;
        waitCnt <= txValid && txReady && txWord.kind == replay_pkg::WORD_CMD ? 12
            : waitCnt - int'(waitCnt > 0);
    end
endmodule

// File: tb/tb_top.sv
// bench: apb setup, buffer ram, replay runs
// assumes the bus side model and checker
`timescale 1ns/1ps
module tb_top;
    logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, memAck = 0, answer = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, memData = 0, prdata, memAddr, rd, ram [0:63];
    logic pready, pslverr, memReq, txValid, txReady, rxValid, tagValid, halfIntr, replayActive;
    replay_pkg::tx_word_type txWord;
    int num_errors = 0, checks_done = 0, nTx = 0, nTag = 0, nHalf = 0, n, t0, g0, h0, k;
    bus_traffic_replay_engine #(.BUF_BYTES(256)) dut_u (.*, .clkEn(1'h1), .tagOut(),
        .bcEnable(), .rtEnable(), .monEnable());
    bus_side_model bus_u (.*);
    initial forever #50 clk = ~clk;
    always @(posedge clk)
    begin
        memAck <= memReq && !memAck;
        memData <= memReq && !memAck ? ram[memAddr[7:2]] : ~memData;
        nTx <= nTx + int'(txValid && txReady);
        nTag <= nTag + int'(tagValid);
        nHalf <= nHalf + int'(halfIntr);
    end
    task automatic check(input string s, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %0h seen %0h", s, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        // error shows as all ones
        rd = pslverr ? 32'hFFFF_FFFF : prdata;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask
    task automatic run(input logic [31:0] bytes, ctrl);
        apb(1'h1, replay_pkg::BYTES_OFF, bytes);
        apb(1'h1, replay_pkg::CTRL_OFF, ctrl);
        apb(1'h1, replay_pkg::CTRL_OFF, ctrl | 32'h100);
        for (n = 0; n < 3000 && (n < 3 || replayActive); n++) @(posedge clk);
        check("stopped", replayActive, 32'h0);
    endtask
    function automatic logic [31:0] cnt(input logic [3:0] lo, hi);
        cnt = 0;
        for (int i = 0; i < 96; i++)
            cnt += 32'(ram[i % 64][31:28] >= lo && ram[i % 64][31:28] <= hi);
    endfunction
    initial
    begin
        void'($urandom(7362));
        repeat (16) @(posedge clk);
        resetn <= 1'h1;
        repeat (4) @(posedge clk);
        apb(1'h0, replay_pkg::TIMEOUT_OFF, 32'h0);
        check("timeout", rd, 32'(replay_pkg::TIMEOUT_RST));
        apb(1'h0, 12'h01C, 32'h0);
        check("unmapped", rd, 32'hFFFF_FFFF);
        apb(1'h1, replay_pkg::CTRL_OFF, 32'h3);
        apb(1'h0, replay_pkg::STATUS_OFF, 32'h0);
        check("refused", rd & 32'h2, 32'h2);
        $display("register test done");
        for (int m = 0; m < 3; m++)
        begin
            foreach (ram[i])
            begin
                k = ($urandom % 11) + 1;
                // unused codes 4..7 moved onto the bus word codes
                ram[i] = {4'(k > 3 ? k + 4 : k), 28'($urandom)};
            end
            t0 = nTx;
            g0 = nTag;
            h0 = nHalf;
            run(32'h180, 32'(13 | m << 5 | (m == 1 ? 16 : 0)));
            check("words", nTx - t0, cnt(4'h8, 4'hF));
            check("tags", nTag - g0, m > 0 ? cnt(4'h2, 4'(m + 1)) : 32'h0);
            check("irqs", nHalf - h0, m == 1 ? 32'h3 : 32'h0);
            apb(1'h0, replay_pkg::HALFCNT_OFF, 32'h0);
            check("halves", rd, 32'(3 * m + 3));
            apb(1'h0, replay_pkg::CTRL_OFF, 32'h0);
            check("ctrl", rd, 32'(13 | m << 5 | (m == 1 ? 16 : 0)));
            $display("replay run %0d done", m);
        end
        ram[0] = 32'h8000_2C00;
        ram[1] = 32'hA000_1234;
        ram[2] = 32'hB000_2800;
        ram[3] = 32'h0;
        apb(1'h1, replay_pkg::RTDIS_OFF, 32'h20);
        apb(1'h1, replay_pkg::TIMEOUT_OFF, 32'h28);
        for (int a = 0; a < 2; a++)
        begin
            answer <= a[0];
            t0 = nTx;
            run(32'h20, 32'h1);
            check("live words", nTx - t0, 32'h1);
            apb(1'h0, replay_pkg::BYTES_OFF, 32'h0);
            check("left", rd, 32'h4);
            check("answered early", 32'(n < 40), 32'(a));
        end
        $display("live terminal test done");
        end_of_test;
    end
    initial
    begin
        #(20000 * 100);
        num_errors++;
        end_of_test;
    end
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
endmodule
